// File: core/bgc_pkg.sv
// Constants, register map and types for the bargraph scale and calibration core
package bgc_pkg;
	// Clock rate and flash half period
	localparam int unsigned CLK_HZ         = 32'h0098_9680;
	localparam int unsigned FLASH_HALF_MS  = 32'h0000_00fa;
	localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 32'h0000_03e8);
	// Reading range and internal signal limits, in counts
	localparam logic signed [15:0] NUMERIC_READOUT_SWITCH_MIN     = -16'sh07cf;
	localparam logic signed [15:0] NUMERIC_READOUT_SWITCH_MAX     = 16'sh270f;
	localparam logic signed [15:0] RAW_MIN      = -16'sh03e8;
	localparam logic signed [15:0] RAW_MAX      = 16'sh07d0;
	localparam logic signed [31:0] CAL_MIN_DIFF = 32'sh0000_03e8;
	localparam logic signed [31:0] NUMERIC_READOUT_SWITCH_SPAN    = 32'sh0000_2ee0;
	localparam logic signed [31:0] RAW_SPAN     = 32'sh0000_0bb8;
	// Bargraph and converter geometry
	localparam int          BAR_SEGS  = 101;
	localparam logic [31:0] BAR_FULL  = 32'h0000_0064;
	localparam logic [6:0]  BAR_TOP   = 7'h64;
	localparam logic [6:0]  BAR_MID   = 7'h32;
	localparam logic [31:0] DAC_FULL  = 32'h0000_ffff;
	localparam int          GAIN_FRAC = 12;
	localparam logic [5:0]  DIV_LAST  = 6'h1f;
	// Register byte offsets
	localparam logic [11:0] REG_STATUS  = 12'h000;
	localparam logic [11:0] REG_READING = 12'h004;
	localparam logic [11:0] REG_AN_HI   = 12'h008;
	localparam logic [11:0] REG_AN_LO   = 12'h00c;
	localparam logic [11:0] REG_BAR_HI  = 12'h010;
	localparam logic [11:0] REG_BAR_LO  = 12'h014;
	localparam logic [11:0] REG_MODE    = 12'h018;
	localparam logic [11:0] REG_GAIN    = 12'h01c;
	localparam int MODE_CENTER_BIT  = 0;
	localparam int MODE_READOUT_BIT = 1;
	// Reset values of the stored settings
	localparam logic signed [15:0] AN_HI_RST  = 16'sh03e8;
	localparam logic signed [15:0] AN_LO_RST  = 16'sh0000;
	localparam logic signed [15:0] BAR_HI_RST = 16'sh0064;
	localparam logic signed [15:0] BAR_LO_RST = 16'sh0000;
	localparam logic signed [15:0] CAL_LO_RST = 16'sh0000;
	localparam logic signed [15:0] CAL_HI_RST = 16'sh03e8;
	localparam logic signed [31:0] GAIN_RST   = 32'sh0000_1000;
	// Menu states and divider jobs
	typedef enum logic [3:0] {
		S_NORMAL, S_CAL_PROMPT, S_CAL_TYPE, S_CAL_LOW, S_CAL_HIGH, S_CAL_CALC, S_CAL_ERR,
		S_BAR_HI, S_BAR_LO, S_AN_HI, S_AN_LO, S_CENTER, S_READOUT
	} bgc_state_t;
	typedef enum logic [1:0] {J_BAR, J_DAC, J_CAL} bgc_job_t;
endpackage : bgc_pkg

// File: core/bgc_core.sv
// Bargraph meter menu, two-point calibration, bar mapping and analog point logic
// Behaviour
// - Analog high and low points accept any reading from -1999 to 9999.
// - Analog high below analog low gives an inverted converter output.
// - Analog span may be as small as one count; output then steps coarsely.
// - Program press after analog high shows the stored analog low point.
// - Program press after analog low shows the center-zero on/off choice.
// - Readout off: after menu exit digits blank, bargraph stays lit.
// - Any button press lights digits while programming; they blank again after.
// - Bargraph scaled between its own lower and upper reading limits.
// - Below lower limit no segments; between limits proportional; full at upper limit.
// - Above upper limit the bargraph flashes.
// - Center mode: bar runs from center segment to the reading's segment.
// - Center mode: reading at midpoint lights only the center segment.
// - Two-point calibration computes and stores a new scale factor.
// - High input must exceed low input by 1000 counts or calibration fails.
// - Calibration fails if the scale needs more than the reading range.
// - Input beyond internal signal limits always flags overrange.
// - Calibration prompt starts off; up/down sets on; program offers type choice.
// - Without analog output hardware the type choice is skipped to high step.
// - Input choice plus program shows low step; confirming it shows high step.
// - Successful calibration continues to bargraph upper limit with stored value.
// - Failed calibration shows error, drops new entries, keeps old calibration.
// - Program plus down in normal operation enters menu at calibration prompt off.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bgc_core
	import bgc_pkg::*;
#(
	parameter int unsigned FLASH_CYC = bgc_pkg::FLASH_HALF_CYC
) (
	input  wire  logic                     pclk,
	input  wire  logic                     presetn,
	input  wire  logic [11:0]              paddr,
	input  wire  logic                     psel,
	input  wire  logic                     penable,
	input  wire  logic                     pwrite,
	input  wire  logic [31:0]              pwdata,
	output var   logic [31:0]              prdata,
	output var   logic                     pready,
	output var   logic                     pslverr,
	input  wire  logic                     btn_prog,
	input  wire  logic                     btn_up,
	input  wire  logic                     btn_down,
	input  wire  logic signed [15:0]       raw_count,
	input  wire  logic                     input_over,
	input  wire  logic                     analog_present,
	output var   logic [BAR_SEGS-1:0]      bar_seg,
	output var   logic                     digits_on,
	output var   logic signed [15:0]       numeric_readout_switch_value,
	output var   bgc_pkg::bgc_state_t      menu_state,
	output var   logic                     cal_error,
	output var   logic                     overrange,
	output var   logic [15:0]              dac_code
);
	import bgc_pkg::*;

	function automatic logic signed [15:0] clamp_numeric_readout_switch(input logic signed [31:0] v);
		if (v > 32'(NUMERIC_READOUT_SWITCH_MAX))
			return NUMERIC_READOUT_SWITCH_MAX;
		if (v < 32'(NUMERIC_READOUT_SWITCH_MIN))
			return NUMERIC_READOUT_SWITCH_MIN;
		return v[15:0];
	endfunction : clamp_numeric_readout_switch

	function automatic logic [31:0] mag(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction : mag

	bgc_state_t               state_reg;
	logic signed [15:0]       edit_reg, an_hi_reg, an_lo_reg, bar_hi_reg, bar_lo_reg;
	logic signed [15:0]       cal_rl_reg, cal_dl_reg, cal_rh_reg, cal_dh_reg;
	logic signed [15:0]       tmp_rl_reg, tmp_dl_reg, tmp_rh_reg, tmp_dh_reg;
	logic signed [31:0]       cal_gain_reg, cal_quo_reg;
	logic                     flag_reg, center_reg, readout_reg, err_reg;
	logic [2:0]               btn_prev_reg;
	logic                     prog_evt, up_evt, dn_evt, combo_evt, any_btn;
	logic                     value_state, flag_state, apb_wr;
	logic signed [31:0]       hi_diff, hi_span;
	logic signed [15:0]       reading_reg;
	logic                     over_reg;
	logic                     div_busy, cal_done_reg, div_neg;
	bgc_job_t                 div_job, next_job;
	logic [5:0]               div_cnt;
	logic [16:0]              div_rem, rem_s;
	logic [31:0]              div_quo;
	logic [15:0]              div_den;
	logic                     q_bit;
	logic [31:0]              q_full;
	logic [6:0]               bar_pos_reg;
	logic [31:0]              flash_cnt;
	logic                     flash_on;
	logic [31:0]              rd_data;
	logic                     rd_hit;

	// Button press edges; a lone program press never fires while down is held
	always_ff @(posedge pclk or negedge presetn) begin : btn_edge
		if (!presetn)
			btn_prev_reg <= 3'h0;
		else
			btn_prev_reg <= {btn_prog, btn_up, btn_down};
	end
	assign prog_evt  = btn_prog && !btn_prev_reg[2] && !btn_down;
	assign up_evt    = btn_up && !btn_prev_reg[1];
	assign dn_evt    = btn_down && !btn_prev_reg[0] && !btn_prog;
	assign combo_evt = btn_prog && btn_down && !(btn_prev_reg[2] && btn_prev_reg[0]);
	assign any_btn   = btn_prog || btn_up || btn_down;

	assign value_state = state_reg inside {S_CAL_LOW, S_CAL_HIGH, S_BAR_HI, S_BAR_LO, S_AN_HI, S_AN_LO};
	assign flag_state  = state_reg inside {S_CAL_PROMPT, S_CAL_TYPE, S_CENTER, S_READOUT};
	assign apb_wr      = psel && penable && pwrite && pready;
	// Checks on the just-confirmed high point against the held low point
	assign hi_diff = 32'(raw_count) - 32'(tmp_rl_reg);
	assign hi_span = 32'(mag(32'(edit_reg) - 32'(tmp_dl_reg)));

	// Menu walk and stored settings; software writes only land in normal operation
	always_ff @(posedge pclk or negedge presetn) begin : menu_fsm
		if (!presetn) begin
			state_reg    <= S_NORMAL;
			edit_reg     <= 16'sh0000;
			flag_reg     <= 1'b0;
			err_reg      <= 1'b0;
			an_hi_reg    <= AN_HI_RST;
			an_lo_reg    <= AN_LO_RST;
			bar_hi_reg   <= BAR_HI_RST;
			bar_lo_reg   <= BAR_LO_RST;
			center_reg   <= 1'b0;
			readout_reg  <= 1'b1;
			cal_rl_reg   <= CAL_LO_RST;
			cal_dl_reg   <= CAL_LO_RST;
			cal_rh_reg   <= CAL_HI_RST;
			cal_dh_reg   <= CAL_HI_RST;
			cal_gain_reg <= GAIN_RST;
			tmp_rl_reg   <= CAL_LO_RST;
			tmp_dl_reg   <= CAL_LO_RST;
			tmp_rh_reg   <= CAL_HI_RST;
			tmp_dh_reg   <= CAL_HI_RST;
		end else begin
			// Step by one count, held at the range ends
			if (value_state && up_evt)
				edit_reg <= clamp_numeric_readout_switch(32'(edit_reg) + 32'sh0000_0001);
			else if (value_state && dn_evt)
				edit_reg <= clamp_numeric_readout_switch(32'(edit_reg) - 32'sh0000_0001);
			if (flag_state && (up_evt || dn_evt))
				flag_reg <= !flag_reg;
			unique case (state_reg)
				S_NORMAL: begin
					if (combo_evt) begin
						state_reg <= S_CAL_PROMPT;
						flag_reg  <= 1'b0;
					end else if (apb_wr) begin
						// Values outside the reading range are clamped, not refused
						case (paddr)
							REG_AN_HI:  an_hi_reg  <= clamp_numeric_readout_switch(32'(signed'(pwdata[15:0])));
							REG_AN_LO:  an_lo_reg  <= clamp_numeric_readout_switch(32'(signed'(pwdata[15:0])));
							REG_BAR_HI: bar_hi_reg <= clamp_numeric_readout_switch(32'(signed'(pwdata[15:0])));
							REG_BAR_LO: bar_lo_reg <= clamp_numeric_readout_switch(32'(signed'(pwdata[15:0])));
							REG_MODE: begin
								center_reg  <= pwdata[MODE_CENTER_BIT];
								readout_reg <= pwdata[MODE_READOUT_BIT];
							end
							default: ;
						endcase
					end
				end
				S_CAL_PROMPT: if (prog_evt) begin
					if (!flag_reg) begin
						state_reg <= S_BAR_HI;
						edit_reg  <= bar_hi_reg;
					end else if (analog_present) begin
						state_reg <= S_CAL_TYPE;
						flag_reg  <= 1'b0;
					end else begin
						// Skipped low step reuses the stored low point
						state_reg  <= S_CAL_HIGH;
						edit_reg   <= cal_dh_reg;
						tmp_rl_reg <= cal_rl_reg;
						tmp_dl_reg <= cal_dl_reg;
					end
				end
				S_CAL_TYPE: if (prog_evt) begin
					// Output trim lives elsewhere; choosing it just leaves
					if (flag_reg) begin
						state_reg <= S_CAL_LOW;
						edit_reg  <= cal_dl_reg;
					end else
						state_reg <= S_NORMAL;
				end
				S_CAL_LOW: if (prog_evt) begin
					tmp_rl_reg <= raw_count;
					tmp_dl_reg <= edit_reg;
					state_reg  <= S_CAL_HIGH;
					edit_reg   <= cal_dh_reg;
				end
				S_CAL_HIGH: if (prog_evt) begin
					tmp_rh_reg <= raw_count;
					tmp_dh_reg <= edit_reg;
					if (hi_diff < CAL_MIN_DIFF) begin
						state_reg <= S_CAL_ERR;
						err_reg   <= 1'b1;
					end else if (hi_span * RAW_SPAN > NUMERIC_READOUT_SWITCH_SPAN * hi_diff) begin
						state_reg <= S_CAL_ERR;
						err_reg   <= 1'b1;
					end else
						state_reg <= S_CAL_CALC;
				end
				S_CAL_CALC: if (cal_done_reg) begin
					cal_gain_reg <= cal_quo_reg;
					cal_rl_reg   <= tmp_rl_reg;
					cal_dl_reg   <= tmp_dl_reg;
					cal_rh_reg   <= tmp_rh_reg;
					cal_dh_reg   <= tmp_dh_reg;
					state_reg    <= S_BAR_HI;
					edit_reg     <= bar_hi_reg;
				end
				S_CAL_ERR: if (prog_evt || up_evt || dn_evt) begin
					state_reg <= S_NORMAL;
					err_reg   <= 1'b0;
				end
				S_BAR_HI: if (prog_evt) begin
					bar_hi_reg <= edit_reg;
					state_reg  <= S_BAR_LO;
					edit_reg   <= bar_lo_reg;
				end
				S_BAR_LO: if (prog_evt) begin
					bar_lo_reg <= edit_reg;
					if (analog_present) begin
						state_reg <= S_AN_HI;
						edit_reg  <= an_hi_reg;
					end else begin
						state_reg <= S_CENTER;
						flag_reg  <= center_reg;
					end
				end
				S_AN_HI: if (prog_evt) begin
					an_hi_reg <= edit_reg;
					state_reg <= S_AN_LO;
					edit_reg  <= an_lo_reg;
				end
				S_AN_LO: if (prog_evt) begin
					an_lo_reg <= edit_reg;
					state_reg <= S_CENTER;
					flag_reg  <= center_reg;
				end
				S_CENTER: if (prog_evt) begin
					center_reg <= flag_reg;
					state_reg  <= S_READOUT;
					flag_reg   <= readout_reg;
				end
				S_READOUT: if (prog_evt) begin
					readout_reg <= flag_reg;
					state_reg   <= S_NORMAL;
				end
			endcase
		end
	end

	// Reading from the stored scale factor, and overrange from the raw signal
	always_ff @(posedge pclk or negedge presetn) begin : reading_calc
		logic signed [31:0] rdiff;
		logic signed [47:0] prod;
		if (!presetn) begin
			reading_reg <= 16'sh0000;
			over_reg    <= 1'b0;
		end else begin
			rdiff       = 32'(raw_count) - 32'(cal_rl_reg);
			prod        = (48'(rdiff) * 48'(cal_gain_reg)) >>> GAIN_FRAC;
			reading_reg <= clamp_numeric_readout_switch(32'(prod) + 32'(cal_dl_reg));
			over_reg    <= input_over || raw_count < RAW_MIN || raw_count > RAW_MAX;
		end
	end

	// One shared serial divider: bar position and converter code in turn, calibration first
	assign next_job = (state_reg == S_CAL_CALC && !cal_done_reg) ? J_CAL : (div_job == J_BAR ? J_DAC : J_BAR);
	assign rem_s    = {div_rem[15:0], div_quo[31]};
	// Full quotient at the last step includes the bit decided in that same cycle
	assign q_bit    = rem_s >= {1'b0, div_den};
	assign q_full   = {div_quo[30:0], q_bit};
	always_ff @(posedge pclk or negedge presetn) begin : divider
		logic signed [31:0] d, s;
		if (!presetn) begin
			div_busy     <= 1'b0;
			div_job      <= J_BAR;
			div_cnt      <= 6'h00;
			div_rem      <= 17'h0_0000;
			div_quo      <= 32'h0000_0000;
			div_den      <= 16'h0001;
			div_neg      <= 1'b0;
			bar_pos_reg  <= 7'h00;
			dac_code     <= 16'h0000;
			cal_quo_reg  <= GAIN_RST;
			cal_done_reg <= 1'b0;
		end else begin
			cal_done_reg <= 1'b0;
			if (!div_busy) begin
				div_busy <= 1'b1;
				div_job  <= next_job;
				div_cnt  <= 6'h00;
				div_rem  <= 17'h0_0000;
				unique case (next_job)
					J_BAR: begin
						d = 32'(reading_reg) - 32'(bar_lo_reg);
						s = 32'(bar_hi_reg) - 32'(bar_lo_reg);
						div_neg <= 1'b0;
						div_den <= (s > 0) ? s[15:0] : 16'h0001;
						div_quo <= (s > 0 && !d[31]) ? 32'(d * BAR_FULL) : 32'h0000_0000;
					end
					J_DAC: begin
						// Either sign of span works, so reversed points invert the output
						d = 32'(reading_reg) - 32'(an_lo_reg);
						s = 32'(an_hi_reg) - 32'(an_lo_reg);
						div_neg <= d[31] ^ s[31];
						div_den <= (s != 0) ? 16'(mag(s)) : 16'h0001;
						div_quo <= (s != 0) ? 32'(mag(d) * DAC_FULL) : 32'h0000_0000;
					end
					J_CAL: begin
						d = 32'(tmp_dh_reg) - 32'(tmp_dl_reg);
						s = 32'(tmp_rh_reg) - 32'(tmp_rl_reg);
						div_neg <= d[31];
						div_den <= s[15:0];
						div_quo <= mag(d) << GAIN_FRAC;
					end
				endcase
			end else begin
				if (q_bit) begin
					div_rem <= rem_s - {1'b0, div_den};
					div_quo <= {div_quo[30:0], 1'b1};
				end else begin
					div_rem <= rem_s;
					div_quo <= {div_quo[30:0], 1'b0};
				end
				div_cnt <= div_cnt + 6'h01;
				if (div_cnt == DIV_LAST) begin
					div_busy <= 1'b0;
					unique case (div_job)
						J_BAR: bar_pos_reg <= (q_full >= BAR_FULL) ? BAR_TOP : q_full[6:0];
						J_DAC: dac_code <= div_neg ? 16'h0000 : (q_full >= DAC_FULL ? 16'hffff : q_full[15:0]);
						J_CAL: begin
							cal_quo_reg  <= div_neg ? -32'(signed'({div_quo[30:0], 1'b0})) : 32'(signed'({div_quo[30:0], 1'b0}));
							cal_done_reg <= 1'b1;
						end
					endcase
				end
			end
		end
	end

	// Flash phase for bargraph overrange
	always_ff @(posedge pclk or negedge presetn) begin : flash_timer
		if (!presetn) begin
			flash_cnt <= 32'h0000_0000;
			flash_on  <= 1'b1;
		end else if (flash_cnt >= FLASH_CYC - 32'h0000_0001) begin
			flash_cnt <= 32'h0000_0000;
			flash_on  <= !flash_on;
		end else
			flash_cnt <= flash_cnt + 32'h0000_0001;
	end

	// Segment pattern; above the upper limit the whole bar blinks
	always_ff @(posedge pclk or negedge presetn) begin : bar_render
		logic [6:0] lo, hi;
		if (!presetn)
			bar_seg <= '0;
		else begin
			lo = center_reg ? ((bar_pos_reg < BAR_MID) ? bar_pos_reg : BAR_MID) : 7'h00;
			hi = center_reg ? ((bar_pos_reg > BAR_MID) ? bar_pos_reg : BAR_MID) : bar_pos_reg;
			for (int i = 0; i < BAR_SEGS; i++) begin
				if (over_reg || reading_reg > bar_hi_reg)
					bar_seg[i] <= flash_on;
				else if (reading_reg < bar_lo_reg)
					bar_seg[i] <= 1'b0;
				else
					bar_seg[i] <= (7'(i) >= lo) && (7'(i) <= hi);
			end
		end
	end

	// Front panel outputs
	always_ff @(posedge pclk or negedge presetn) begin : panel_out
		if (!presetn) begin
			digits_on  <= 1'b1;
			numeric_readout_switch_value <= 16'sh0000;
			menu_state <= S_NORMAL;
			cal_error  <= 1'b0;
			overrange  <= 1'b0;
		end else begin
			digits_on  <= readout_reg || state_reg != S_NORMAL || any_btn;
			numeric_readout_switch_value <= (state_reg == S_NORMAL) ? reading_reg : (flag_state ? 16'(flag_reg) : edit_reg);
			menu_state <= state_reg;
			cal_error  <= err_reg;
			overrange  <= over_reg;
		end
	end

	// Register read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h0000_0000;
		case (paddr)
			REG_STATUS:  rd_data = {24'h00_0000, 4'(state_reg), err_reg, over_reg, analog_present, digits_on};
			REG_READING: rd_data = 32'(reading_reg);
			REG_AN_HI:   rd_data = 32'(an_hi_reg);
			REG_AN_LO:   rd_data = 32'(an_lo_reg);
			REG_BAR_HI:  rd_data = 32'(bar_hi_reg);
			REG_BAR_LO:  rd_data = 32'(bar_lo_reg);
			REG_MODE:    rd_data = {30'h0000_0000, readout_reg, center_reg};
			REG_GAIN:    rd_data = cal_gain_reg;
			default:     rd_hit = 1'b0;
		endcase
	end

	// Zero-wait slave: data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin : apb_slave
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= !rd_hit;
			end
		end
	end

	// Checks
	clamp_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		value_state |-> (edit_reg >= NUMERIC_READOUT_SWITCH_MIN && edit_reg <= NUMERIC_READOUT_SWITCH_MAX)) else $error("edit value out of range");
	an_advance_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_AN_HI && prog_evt) |=> (state_reg == S_AN_LO && edit_reg == $past(an_lo_reg)))
		else $error("analog low step not shown");
	center_next_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_AN_LO && prog_evt) |=> (state_reg == S_CENTER && flag_reg == center_reg))
		else $error("center choice not shown");
	digits_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_NORMAL && !readout_reg && !any_btn)[*2] |-> !digits_on) else $error("digits not blanked");
	digits_menu_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg != S_NORMAL) |=> digits_on) else $error("digits dark in menu");
	cal_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_CAL_PROMPT && prog_evt && flag_reg && !analog_present) |=> state_reg == S_CAL_HIGH)
		else $error("type choice not skipped");
	span_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_CAL_HIGH && prog_evt && hi_diff < CAL_MIN_DIFF) |=> (state_reg == S_CAL_ERR && err_reg))
		else $error("small span accepted");
	err_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_CAL_ERR) |=> $stable(cal_gain_reg) && $stable(cal_rl_reg)) else $error("calibration changed");
	enter_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_NORMAL && combo_evt) |=> (state_reg == S_CAL_PROMPT && !flag_reg))
		else $error("menu entry wrong");
	cal_done_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_CAL_CALC) |-> ##[1:70] (state_reg == S_BAR_HI)) else $error("calibration did not finish");
endmodule : bgc_core
`default_nettype wire

// File: verification/bgc_panel.sv
// Front panel push button model for the bargraph core
`timescale 1ns/100ps
`default_nettype none
module bgc_panel (
	input  wire logic pclk,
	output var  logic btn_prog,
	output var  logic btn_up,
	output var  logic btn_down
);
	// Buttons start released, pulled low
	initial begin
		btn_prog = 1'b0;
		btn_up   = 1'b0;
		btn_down = 1'b0;
	end
	// Held three edges, then released long enough that the next call is a fresh press
	task automatic press(input logic p, input logic u, input logic d);
		@(posedge pclk);
		btn_prog <= p;
		btn_up   <= u;
		btn_down <= d;
		repeat (3) @(posedge pclk);
		btn_prog <= 1'b0;
		btn_up   <= 1'b0;
		btn_down <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : press
endmodule : bgc_panel
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the bargraph scale and calibration core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import bgc_pkg::*;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rdat;
	logic               btn_prog, btn_up, btn_down, input_over, analog_present;
	logic               digits_on, cal_error, overrange;
	logic signed [15:0] raw_count, numeric_readout_switch_value;
	logic [100:0]       bar_seg;
	logic [15:0]        dac_code;
	bgc_state_t         menu_state;
	int                 num_errors, checks, k, hi_n, lo_n;

	bgc_panel u_panel (.pclk, .btn_prog, .btn_up, .btn_down);
	bgc_core #(.FLASH_CYC(4)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .btn_prog, .btn_up, .btn_down, .raw_count, .input_over, .analog_present,
		.bar_seg, .digits_on, .numeric_readout_switch_value, .menu_state, .cal_error, .overrange, .dac_code);

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	// Compare and count
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			finish_test();
		end
	endtask : apb
	// Bar mask from segment lo to hi
	function automatic logic [100:0] segs(input int lo, input int hi);
		segs = '0;
		for (int i = lo; i <= hi; i++) segs[i] = 1'b1;
	endfunction : segs
	// Wait, bounded, for the bar or converter output to settle
	task automatic settle(input bit dac, input logic [127:0] e);
		// Let the new input reach the reading; divider results can still be stale after these three cycles
		repeat (3) @(posedge pclk);
		for (k = 0; k < 400 && (dac ? 101'(dac_code) : bar_seg) !== e; k++) @(posedge pclk);
		chk(dac ? 101'(dac_code) : bar_seg, e);
	endtask : settle
	// Press buttons {prog,up,down}, then check state and shown value
	task automatic step(input logic [2:0] b, input bgc_state_t s, input logic [15:0] v);
		u_panel.press(b[2], b[1], b[0]);
		chk({menu_state, numeric_readout_switch_value}, {s, v});
	endtask : step

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, input_over} = '0;
		raw_count = 16'sh0000;
		analog_present = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, REG_AN_HI, 0); chk(rdat, 32'h0000_03e8);
		apb(0, REG_BAR_HI, 0); chk(rdat, 32'h0000_0064);
		apb(0, REG_MODE, 0); chk(rdat, 32'h0000_0002);
		apb(0, 12'h020, 0); chk({rerr, rdat}, {1'b1, 32'h0000_0000});
		$display("reset test done");
		step(3'b101, S_CAL_PROMPT, 16'h0000);
		step(3'b100, S_BAR_HI, 16'h0064);
		step(3'b100, S_BAR_LO, 16'h0000);
		step(3'b100, S_AN_HI, 16'h03e8);
		step(3'b010, S_AN_HI, 16'h03e9);
		step(3'b100, S_AN_LO, 16'h0000);
		step(3'b100, S_CENTER, 16'h0000);
		step(3'b100, S_READOUT, 16'h0001);
		step(3'b010, S_READOUT, 16'h0000);
		step(3'b100, S_NORMAL, 16'h0000);
		chk(digits_on, 1'b0);
		apb(0, REG_AN_HI, 0); chk(rdat, 32'h0000_03e9);
		$display("menu test done");
		apb(1, REG_AN_LO, 32'h0000_7fff); apb(0, REG_AN_LO, 0); chk(rdat, 32'h0000_270f);
		apb(1, REG_AN_HI, 0); apb(1, REG_AN_LO, 32'h0000_03e8);
		raw_count <= 16'sd50;
		settle(1, 16'hf332);
		apb(1, REG_AN_HI, 32'h0000_0002); apb(1, REG_AN_LO, 0);
		raw_count <= 16'sd1;
		settle(1, 16'h7fff);
		$display("analog test done");
		raw_count <= 16'sd50;
		settle(0, segs(0, 50));
		raw_count <= 16'sd100;
		settle(0, segs(0, 100));
		raw_count <= 16'sd150;
		settle(0, segs(0, 100));
		{hi_n, lo_n} = '0;
		repeat (30) begin
			@(posedge pclk);
			hi_n += (bar_seg === '1);
			lo_n += (bar_seg === '0);
		end
		chk({hi_n > 0, lo_n > 0}, 2'b11);
		apb(1, REG_BAR_LO, 32'h0000_0014);
		raw_count <= 16'sd10;
		settle(0, '0);
		apb(1, REG_BAR_LO, 0); apb(1, REG_MODE, 32'h0000_0001);
		raw_count <= 16'sd50;
		settle(0, segs(50, 50));
		raw_count <= 16'sd80;
		settle(0, segs(50, 80));
		raw_count <= 16'sd20;
		settle(0, segs(20, 50));
		raw_count <= 16'sd2500;
		repeat (10) @(posedge pclk);
		chk(overrange, 1'b1);
		input_over <= 1'b1;
		raw_count <= 16'sd0;
		repeat (4) @(posedge pclk);
		chk(overrange, 1'b1);
		input_over <= 1'b0;
		$display("bar test done");
		raw_count <= 16'sd0;
		step(3'b101, S_CAL_PROMPT, 16'h0000);
		chk(digits_on, 1'b1);
		chk(overrange, 1'b0);
		step(3'b010, S_CAL_PROMPT, 16'h0001);
		step(3'b100, S_CAL_TYPE, 16'h0000);
		step(3'b010, S_CAL_TYPE, 16'h0001);
		step(3'b100, S_CAL_LOW, 16'h0000);
		step(3'b100, S_CAL_HIGH, 16'h03e8);
		raw_count <= 16'sd500;
		u_panel.press(1'b1, 1'b0, 1'b0);
		chk({menu_state, cal_error}, {S_CAL_ERR, 1'b1});
		step(3'b100, S_NORMAL, 16'h01f4);
		chk(digits_on, 1'b0);
		apb(0, REG_GAIN, 0); chk(rdat, 32'h0000_1000);
		analog_present <= 1'b0;
		raw_count <= 16'sd2000;
		step(3'b101, S_CAL_PROMPT, 16'h0000);
		step(3'b010, S_CAL_PROMPT, 16'h0001);
		step(3'b100, S_CAL_HIGH, 16'h03e8);
		u_panel.press(1'b1, 1'b0, 1'b0);
		for (k = 0; k < 300 && menu_state !== S_BAR_HI; k++) @(posedge pclk);
		chk({menu_state, numeric_readout_switch_value}, {S_BAR_HI, 16'h0064});
		for (int i = 0; i < 9 && menu_state !== S_NORMAL; i++) u_panel.press(1'b1, 1'b0, 1'b0);
		chk(menu_state, S_NORMAL);
		apb(0, REG_GAIN, 0); chk(rdat, 32'h0000_0800);
		// Mid-run reset brings back the default scale factor
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, REG_GAIN, 0); chk(rdat, 32'h0000_1000);
		$display("calibration test done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
